// File: hw/cvi_defines.svh
// Address map, field positions, reset values and timing of the codec interface
`ifndef CVI_DEFINES_SVH
`define CVI_DEFINES_SVH

// ----------------------------------------------------------------------
// Data memory addresses of the codec registers
// ----------------------------------------------------------------------
`define CVI_ADDR_CTRL 14'h3FEE
`define CVI_ADDR_RX_DATA 14'h3FED
`define CVI_ADDR_TX_DATA 14'h3FEC
`define CVI_ADDR_ABUF 14'h3FEF
`define CVI_ADDR_RX_BASE 14'h3FEB
`define CVI_ADDR_TX_BASE 14'h3FEA

// ----------------------------------------------------------------------
// Codec control register fields
// ----------------------------------------------------------------------
`define CVI_CTRL_ADC_GAIN_LO 0
`define CVI_CTRL_DAC_GAIN_LSB 2
`define CVI_CTRL_DAC_GAIN_MSB 4
`define CVI_CTRL_PWR_A 5
`define CVI_CTRL_PWR_B 6
`define CVI_CTRL_AUX_SEL 8
`define CVI_CTRL_ADC_GAIN_HI 9
`define CVI_CTRL_OFFSET 10
`define CVI_CTRL_MASK 16'h077D
`define CVI_CTRL_RESET 16'h0000

// ----------------------------------------------------------------------
// Autobuffer control register fields
// ----------------------------------------------------------------------
`define CVI_ABUF_RX_EN 0
`define CVI_ABUF_TX_EN 1
`define CVI_ABUF_ADC_HPF 2
`define CVI_ABUF_DAC_HPF 3
`define CVI_ABUF_LEN_LSB 4
`define CVI_ABUF_LEN_MSB 11
`define CVI_ABUF_MASK 16'h0FFF
`define CVI_ABUF_RESET 16'h0000

// ----------------------------------------------------------------------
// Timing: one word each way per sample period
// ----------------------------------------------------------------------
`define CVI_CLK_PERIOD_NS 100
`define CVI_SAMPLE_PERIOD_NS 125000
`define CVI_SAMPLE_CYC (`CVI_SAMPLE_PERIOD_NS / `CVI_CLK_PERIOD_NS)

`endif

// File: hw/cvi_pkg.sv
// Types shared by the codec interface design
package cvi_pkg;
	// Autobuffer transfer sequencer states
	typedef enum logic [1:0] {
		CVI_DMA_IDLE,
		CVI_DMA_RX_WR,
		CVI_DMA_TX_RD,
		CVI_DMA_TX_CAP
	} cvi_dma_state_t;
endpackage

// File: hw/cvi_codec_if.sv
// Voiceband codec interface: control, sample registers, autobuffer, irqs
// Behaviour
// - Control register lives at address 0x3FEE
// - One of two analog inputs feeds ADC
// - ADC gain code from bits 9 and 0
// - Bit 10 adds ADC modulator offset
// - Selectable DAC high-pass filter enable provided
// - DAC gain from bits 2-4, 3dB steps
// - Receive and transmit data registers exchange samples
// - Autobuffer moves samples to/from data memory
// - Separate receive and transmit interrupt requests
// - Interrupt per word, or per autobuffer block
// - One word each way per 8 kHz period
// - Receive irq after new word is stored
// - Transmit irq when transmit register is free
// - Both irqs together, once per sample period, when neither direction uses the autobuffer
// - Interrupts run once both power bits set
`timescale 1ns/1ns
`include "cvi_defines.svh"

module cvi_codec_if #(
	parameter int SAMPLE_CYC = `CVI_SAMPLE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Core data memory access to the mapped registers
	input wire logic [13:0] i_dm_addr,
	input wire logic i_dm_wr,
	input wire logic [15:0] i_dm_wdata,
	output logic [15:0] o_dm_rdata,
	// Autobuffer port into on-chip data memory, read data one cycle late
	output logic o_mem_we,
	output logic o_mem_re,
	output logic [13:0] o_mem_addr,
	output logic [15:0] o_mem_wdata,
	input wire logic [15:0] i_mem_rdata,
	// Converter side
	input wire logic [15:0] i_adc_sample,
	output logic [15:0] o_dac_sample,
	output logic o_aux_input_sel,
	output logic [1:0] o_adc_gain,
	output logic [2:0] o_dac_gain,
	output logic o_adc_offset_en,
	output logic o_adc_hpf_en,
	output logic o_dac_hpf_en,
	output logic o_codec_power_up,
	// Interrupt requests, one-cycle pulses
	output logic o_irq_rx,
	output logic o_irq_tx
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (SAMPLE_CYC < 8 || SAMPLE_CYC > 65535) begin : g_bad_period
		$error("SAMPLE_CYC out of range");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [15:0] ctrl, next_ctrl; // Codec control
	logic [15:0] abuf, next_abuf; // Autobuffer and filter control
	logic [13:0] rx_base, next_rx_base; // Receive block start
	logic [13:0] tx_base, next_tx_base; // Transmit block start
	logic [13:0] rx_ptr, next_rx_ptr; // Next receive word address
	logic [13:0] tx_ptr, next_tx_ptr; // Next transmit word address
	logic [7:0] rx_cnt, next_rx_cnt; // Words done in receive block
	logic [7:0] tx_cnt, next_tx_cnt; // Words done in transmit block
	logic [15:0] rx_data, next_rx_data; // Latest ADC word
	logic [15:0] tx_data, next_tx_data; // Word for next DAC period
	logic [15:0] dac_out, next_dac_out;
	logic [15:0] rdata, next_rdata;
	logic [15:0] cnt, next_cnt; // Sample period counter
	logic irq_rx, next_irq_rx;
	logic irq_tx, next_irq_tx;
	logic mem_we, next_mem_we;
	logic mem_re, next_mem_re;
	logic [13:0] mem_addr, next_mem_addr;
	logic [15:0] mem_wdata, next_mem_wdata;
	cvi_pkg::cvi_dma_state_t state, next_state;

	logic pwr, next_pwr; // Both power bits set, kept in its own flop
	logic tick; // Last cycle of a sample period
	logic rx_ab, tx_ab;
	logic [7:0] blk_last; // Block length minus one

	assign tick = pwr && (cnt == 16'(SAMPLE_CYC - 1));
	assign rx_ab = abuf[`CVI_ABUF_RX_EN];
	assign tx_ab = abuf[`CVI_ABUF_TX_EN];
	assign blk_last = abuf[`CVI_ABUF_LEN_MSB:`CVI_ABUF_LEN_LSB];

	// ------------------------------------------------------------------
	// Converter controls straight from the register flops
	// ------------------------------------------------------------------
	assign o_aux_input_sel = ctrl[`CVI_CTRL_AUX_SEL];
	assign o_adc_gain = {ctrl[`CVI_CTRL_ADC_GAIN_HI],
		ctrl[`CVI_CTRL_ADC_GAIN_LO]};
	assign o_dac_gain = ctrl[`CVI_CTRL_DAC_GAIN_MSB:
		`CVI_CTRL_DAC_GAIN_LSB];
	assign o_adc_offset_en = ctrl[`CVI_CTRL_OFFSET];
	assign o_adc_hpf_en = abuf[`CVI_ABUF_ADC_HPF];
	assign o_dac_hpf_en = abuf[`CVI_ABUF_DAC_HPF];
	assign o_codec_power_up = pwr;
	assign o_dac_sample = dac_out;
	assign o_dm_rdata = rdata;
	assign o_irq_rx = irq_rx;
	assign o_irq_tx = irq_tx;
	assign o_mem_we = mem_we;
	assign o_mem_re = mem_re;
	assign o_mem_addr = mem_addr;
	assign o_mem_wdata = mem_wdata;

	// ------------------------------------------------------------------
	// Sample period timer
	// ------------------------------------------------------------------
	// Held at zero while powered down so the first period is whole
	always_comb begin
		if (!pwr) begin
			next_cnt = 16'h0000;
		end else if (tick) begin
			next_cnt = 16'h0000;
		end else begin
			next_cnt = cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 16'h0000;
		end else begin
			cnt <= next_cnt;
		end
	end

	// ------------------------------------------------------------------
	// Registers, sample movement, autobuffer sequencer and interrupts
	// ------------------------------------------------------------------
	// Autobuffer traffic has priority over a core write to the transmit
	// register in the same cycle; mixing both on one direction is unsafe.
	always_comb begin
		next_ctrl = ctrl;
		next_abuf = abuf;
		next_rx_base = rx_base;
		next_tx_base = tx_base;
		next_rx_ptr = rx_ptr;
		next_tx_ptr = tx_ptr;
		next_rx_cnt = rx_cnt;
		next_tx_cnt = tx_cnt;
		next_rx_data = rx_data;
		next_tx_data = tx_data;
		next_dac_out = dac_out;
		next_irq_rx = 1'b0;
		next_irq_tx = 1'b0;
		next_mem_we = 1'b0;
		next_mem_re = 1'b0;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_state = state;
		// Core writes; unused bits are dropped, not stored
		if (i_dm_wr) begin
			case (i_dm_addr)
				`CVI_ADDR_CTRL: begin
					next_ctrl = i_dm_wdata & `CVI_CTRL_MASK;
				end
				`CVI_ADDR_ABUF: begin
					next_abuf = i_dm_wdata & `CVI_ABUF_MASK;
				end
				`CVI_ADDR_TX_DATA: begin
					next_tx_data = i_dm_wdata;
				end
				`CVI_ADDR_RX_BASE: begin
					next_rx_base = i_dm_wdata[13:0];
					next_rx_ptr = i_dm_wdata[13:0];
					next_rx_cnt = 8'h00;
				end
				`CVI_ADDR_TX_BASE: begin
					next_tx_base = i_dm_wdata[13:0];
					next_tx_ptr = i_dm_wdata[13:0];
					next_tx_cnt = 8'h00;
				end
				default: begin
					// Writes elsewhere are not ours
				end
			endcase
		end
		// Power state follows the new control word, so the pin is a flop
		next_pwr = next_ctrl[`CVI_CTRL_PWR_A] &
			next_ctrl[`CVI_CTRL_PWR_B];
		// Period end: take ADC word, send staged DAC word
		if (tick) begin
			next_rx_data = i_adc_sample;
			next_dac_out = tx_data;
			next_irq_rx = !rx_ab;
			next_irq_tx = !tx_ab;
		end
		case (state)
			cvi_pkg::CVI_DMA_IDLE: begin
				if (tick && rx_ab) begin
					next_mem_we = 1'b1;
					next_mem_addr = rx_ptr;
					next_mem_wdata = i_adc_sample;
					next_state = cvi_pkg::CVI_DMA_RX_WR;
					if (rx_cnt == blk_last) begin
						next_irq_rx = 1'b1;
						next_rx_ptr = rx_base;
						next_rx_cnt = 8'h00;
					end else begin
						next_rx_ptr = rx_ptr + 14'h0001;
						next_rx_cnt = rx_cnt + 8'h01;
					end
				end else if (tick && tx_ab) begin
					next_mem_re = 1'b1;
					next_mem_addr = tx_ptr;
					next_state = cvi_pkg::CVI_DMA_TX_RD;
				end
			end
			cvi_pkg::CVI_DMA_RX_WR: begin
				// Write done; fetch the next DAC word if needed
				if (tx_ab) begin
					next_mem_re = 1'b1;
					next_mem_addr = tx_ptr;
					next_state = cvi_pkg::CVI_DMA_TX_RD;
				end else begin
					next_state = cvi_pkg::CVI_DMA_IDLE;
				end
			end
			cvi_pkg::CVI_DMA_TX_RD: begin
				next_state = cvi_pkg::CVI_DMA_TX_CAP;
			end
			cvi_pkg::CVI_DMA_TX_CAP: begin
				next_tx_data = i_mem_rdata;
				next_state = cvi_pkg::CVI_DMA_IDLE;
				if (tx_cnt == blk_last) begin
					next_irq_tx = 1'b1;
					next_tx_ptr = tx_base;
					next_tx_cnt = 8'h00;
				end else begin
					next_tx_ptr = tx_ptr + 14'h0001;
					next_tx_cnt = tx_cnt + 8'h01;
				end
			end
			default: begin
				next_state = cvi_pkg::CVI_DMA_IDLE;
			end
		endcase
		// Read mux; unmapped addresses read zero
		case (i_dm_addr)
			`CVI_ADDR_CTRL: next_rdata = ctrl;
			`CVI_ADDR_ABUF: next_rdata = abuf;
			`CVI_ADDR_RX_DATA: next_rdata = rx_data;
			`CVI_ADDR_TX_DATA: next_rdata = tx_data;
			`CVI_ADDR_RX_BASE: next_rdata = {2'h0, rx_base};
			`CVI_ADDR_TX_BASE: next_rdata = {2'h0, tx_base};
			default: next_rdata = 16'h0000;
		endcase
	end

	// State flops other than the period counter, with separate receive and transmit request flops
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl <= `CVI_CTRL_RESET;
			pwr <= 1'b0;
			abuf <= `CVI_ABUF_RESET;
			rx_base <= 14'h0000;
			tx_base <= 14'h0000;
			rx_ptr <= 14'h0000;
			tx_ptr <= 14'h0000;
			rx_cnt <= 8'h00;
			tx_cnt <= 8'h00;
			rx_data <= 16'h0000;
			tx_data <= 16'h0000;
			dac_out <= 16'h0000;
			rdata <= 16'h0000;
			irq_rx <= 1'b0;
			irq_tx <= 1'b0;
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			mem_addr <= 14'h0000;
			mem_wdata <= 16'h0000;
			state <= cvi_pkg::CVI_DMA_IDLE;
		end else begin
			ctrl <= next_ctrl;
			pwr <= next_pwr;
			abuf <= next_abuf;
			rx_base <= next_rx_base;
			tx_base <= next_tx_base;
			rx_ptr <= next_rx_ptr;
			tx_ptr <= next_tx_ptr;
			rx_cnt <= next_rx_cnt;
			tx_cnt <= next_tx_cnt;
			rx_data <= next_rx_data;
			tx_data <= next_tx_data;
			dac_out <= next_dac_out;
			rdata <= next_rdata;
			irq_rx <= next_irq_rx;
			irq_tx <= next_irq_tx;
			mem_we <= next_mem_we;
			mem_re <= next_mem_re;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Helper: cycles since the last transmit interrupt
	logic [15:0] gap;
	logic gap_seen;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap <= 16'h0000;
			gap_seen <= 1'b0;
		end else begin
			gap <= irq_tx ? 16'h0000 : gap + 16'h0001;
			gap_seen <= gap_seen | irq_tx;
		end
	end

	property p_ctrl_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			ctrl == ($past(i_dm_wdata) & `CVI_CTRL_MASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control register write not stored");

	property p_input_sel;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			o_aux_input_sel == $past(i_dm_wdata[8]);
	endproperty
	a_input_sel: assert property (p_input_sel)
		else $error("input select does not follow bit 8");

	property p_adc_gain;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			o_adc_gain == {$past(i_dm_wdata[9]), $past(i_dm_wdata[0])};
	endproperty
	a_adc_gain: assert property (p_adc_gain)
		else $error("ADC gain code wrong");

	property p_offset;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			o_adc_offset_en == $past(i_dm_wdata[10]);
	endproperty
	a_offset: assert property (p_offset)
		else $error("offset enable does not follow bit 10");

	property p_dac_gain;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			o_dac_gain == $past(i_dm_wdata[4:2]);
	endproperty
	a_dac_gain: assert property (p_dac_gain)
		else $error("DAC gain code wrong");

	property p_rx_word;
		@(posedge i_clk) disable iff (!i_rst_n)
		tick && !rx_ab |=> o_irq_rx && rx_data == $past(i_adc_sample);
	endproperty
	a_rx_word: assert property (p_rx_word)
		else $error("receive irq without new word");

	property p_tx_word;
		@(posedge i_clk) disable iff (!i_rst_n)
		tick && !tx_ab |=> o_irq_tx && o_dac_sample == $past(tx_data);
	endproperty
	a_tx_word: assert property (p_tx_word)
		else $error("transmit irq without DAC update");

	property p_together;
		@(posedge i_clk) disable iff (!i_rst_n)
		!rx_ab && !tx_ab && $past(!rx_ab && !tx_ab) |->
			o_irq_rx == o_irq_tx;
	endproperty
	a_together: assert property (p_together)
		else $error("receive and transmit irqs not together");

	property p_period;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_irq_tx && gap_seen && $past(pwr, 2) && !tx_ab |->
			gap == 16'(SAMPLE_CYC - 1);
	endproperty
	a_period: assert property (p_period)
		else $error("sample period length wrong");

	property p_quiet;
		@(posedge i_clk) disable iff (!i_rst_n)
		!pwr [*2] |-> !o_irq_rx && !o_irq_tx && !o_mem_we && !o_mem_re;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("activity while powered down");

	property p_power;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_dm_wr && i_dm_addr == `CVI_ADDR_CTRL |=>
			o_codec_power_up ==
				($past(i_dm_wdata[5]) & $past(i_dm_wdata[6]));
	endproperty
	a_power: assert property (p_power)
		else $error("power state does not follow bits 5 and 6");

endmodule

// File: testbench/cvi_mem_model.sv
// On-chip data memory model facing the autobuffer port
`timescale 1ns/1ns
module cvi_mem_model (
	// Clock
	input wire logic i_clk,
	// Autobuffer access from the codec block
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [13:0] i_addr,
	input wire logic [15:0] i_wdata,
	// Read data back to the codec block
	output logic [15:0] o_rdata
);
	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [15:0] mem [0:16383]; // Full 14-bit word space
	logic rd_valid; // Read data is on the bus this cycle
	logic [15:0] rd_word; // Word fetched by the last read
	// Every access is taken at once, there are no wait states
	always @(posedge i_clk) begin
		if (i_we)
			mem[i_addr] <= i_wdata;
		rd_valid <= i_re;
		if (i_re)
			rd_word <= mem[i_addr];
	end
	// Outside the answer cycle show garbage, so a late capture is seen
	assign o_rdata = rd_valid ? rd_word : ~rd_word;
endmodule

// File: testbench/test_voiceband_codec_interface.sv
// Self-checking bench for the voiceband codec interface
`timescale 1ns/1ns
`include "cvi_defines.svh"
`define chk(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
module test_voiceband_codec_interface;
	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	localparam int S = 16; // Short sample period keeps the run brief
	logic i_clk, i_rst_n, i_dm_wr, rd_req, rd_pend, abuf_on;
	logic [13:0] i_dm_addr, o_mem_addr;
	logic [15:0] i_dm_wdata, i_adc_sample, i_mem_rdata, o_dm_rdata;
	logic [15:0] o_mem_wdata, o_dac_sample, last_dac, e16;
	logic o_mem_we, o_mem_re, o_aux_input_sel, o_adc_offset_en;
	logic o_adc_hpf_en, o_dac_hpf_en, o_codec_power_up, o_irq_rx, o_irq_tx;
	logic [1:0] o_adc_gain;
	logic [2:0] o_dac_gain;
	logic [29:0] e30;
	int checks, miscompares, cyc, last_irq, n_rx, n_tx;
	logic [15:0] q_rd[$], q_dac[$]; // Expected read data, DAC words
	logic [29:0] q_wr[$]; // Expected autobuffer {address, data}
	cvi_codec_if #(.SAMPLE_CYC(S)) u_cvi_codec_if (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_dm_addr(i_dm_addr),
		.i_dm_wr(i_dm_wr), .i_dm_wdata(i_dm_wdata), .o_dm_rdata(o_dm_rdata),
		.o_mem_we(o_mem_we), .o_mem_re(o_mem_re), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
		.i_adc_sample(i_adc_sample), .o_dac_sample(o_dac_sample),
		.o_aux_input_sel(o_aux_input_sel), .o_adc_gain(o_adc_gain),
		.o_dac_gain(o_dac_gain), .o_adc_offset_en(o_adc_offset_en),
		.o_adc_hpf_en(o_adc_hpf_en), .o_dac_hpf_en(o_dac_hpf_en),
		.o_codec_power_up(o_codec_power_up), .o_irq_rx(o_irq_rx),
		.o_irq_tx(o_irq_tx));
	cvi_mem_model u_cvi_mem_model (.i_clk(i_clk), .i_we(o_mem_we),
		.i_re(o_mem_re), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
		.o_rdata(i_mem_rdata));
	// 10 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// Cycle count and read pipeline, read data lags the address by one
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		rd_pend <= rd_req;
	end
	// --------------------------------------------------------------
	// Monitor: outputs are settled at the falling edge
	// --------------------------------------------------------------
	always @(negedge i_clk) begin
		if (rd_pend) begin
			e16 = q_rd.pop_front();
			`chk("rdata", e16, o_dm_rdata)
		end
		if (o_mem_we) begin
			e30 = q_wr.pop_front();
			`chk("mem_addr", e30[29:16], o_mem_addr)
			`chk("mem_wdata", e30[15:0], o_mem_wdata)
		end
		// Reset clears the DAC word; that change is not a new sample
		if (i_rst_n && o_dac_sample !== last_dac) begin
			e16 = q_dac.pop_front();
			`chk("dac", e16, o_dac_sample)
		end
		last_dac = o_dac_sample;
		if (o_irq_rx || o_irq_tx) begin
			n_rx += int'(o_irq_rx);
			n_tx += int'(o_irq_tx);
			// Software takes both directions in one routine
			if (!abuf_on) begin
				`chk("irq_rx", 1'b1, o_irq_rx)
				`chk("irq_tx", 1'b1, o_irq_tx)
				if (last_irq >= 0)
					`chk("irq_gap", S, cyc - last_irq)
				last_irq = cyc;
			end
		end
	end
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic wr(input logic [13:0] a, input logic [15:0] d);
		@(negedge i_clk);
		i_dm_addr = a;
		i_dm_wdata = d;
		i_dm_wr = 1'b1;
		@(negedge i_clk);
		i_dm_wr = 1'b0;
	endtask
	task automatic rd(input logic [13:0] a, input logic [15:0] e);
		@(negedge i_clk);
		i_dm_addr = a;
		q_rd.push_back(e);
		rd_req = 1'b1;
		@(negedge i_clk);
		rd_req = 1'b0;
	endtask
	// Bounded wait for an interrupt or an autobuffer write
	task automatic wait_ev(input logic mem_ev);
		int i;
		for (i = 0; i < 4 * S; i++) begin
			@(negedge i_clk);
			if (mem_ev ? o_mem_we : (o_irq_rx || o_irq_tx))
				return;
		end
		miscompares++;
		close_out();
	endtask
	task automatic do_reset();
		i_rst_n = 1'b0;
		repeat (4) @(negedge i_clk);
		i_rst_n = 1'b1;
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		logic [15:0] w, r;
		int k, nr, nt;
		i_dm_wr = 1'b0;
		i_dm_addr = 14'h0000;
		i_dm_wdata = 16'h0000;
		i_adc_sample = 16'h0000;
		rd_req = 1'b0;
		abuf_on = 1'b0;
		checks = 0;
		miscompares = 0;
		cyc = 0;
		last_irq = -1;
		n_rx = 0;
		n_tx = 0;
		w = 16'h0000;
		void'($urandom(66));
		do_reset();
		// Reset values, masking of unused bits, unmapped places
		rd(`CVI_ADDR_CTRL, 16'h0000);
		rd(`CVI_ADDR_ABUF, 16'h0000);
		`chk("power", 1'b0, o_codec_power_up)
		wr(`CVI_ADDR_CTRL, 16'hFFFF);
		rd(`CVI_ADDR_CTRL, 16'h077D);
		wr(14'h3F00, 16'hFFFF);
		rd(14'h3F00, 16'h0000);
		wr(`CVI_ADDR_RX_DATA, 16'hAAAA);
		rd(`CVI_ADDR_RX_DATA, 16'h0000);
		$display("done map");
		// Every gain code, input choice and offset setting
		for (k = 0; k < 8; k++) begin
			// Offset always goes with the ADC high-pass filter
			wr(`CVI_ADDR_ABUF, {12'h000, k[1], k[2], 2'b00});
			wr(`CVI_ADDR_CTRL, {5'h00, k[2], k[1], k[0], 3'b000, k[2:0],
				1'b0, k[0]});
			`chk("adc_gain", k[1:0], o_adc_gain)
			`chk("dac_gain", k[2:0], o_dac_gain)
			`chk("aux", k[0], o_aux_input_sel)
			`chk("offset", k[2], o_adc_offset_en)
			`chk("hpf", k[2:1], {o_adc_hpf_en, o_dac_hpf_en})
		end
		$display("done fields");
		// One power bit alone keeps the codec quiet
		wr(`CVI_ADDR_RX_BASE, 16'h0200);
		wr(`CVI_ADDR_TX_BASE, 16'h0100);
		wr(`CVI_ADDR_CTRL, 16'h0020);
		`chk("power", 1'b0, o_codec_power_up)
		wr(`CVI_ADDR_CTRL, 16'h0040);
		`chk("power", 1'b0, o_codec_power_up)
		repeat (3 * S) @(negedge i_clk);
		`chk("irq_quiet", 0, n_rx + n_tx)
		$display("done powerdown");
		// Word by word exchange through the data registers
		wr(`CVI_ADDR_CTRL, 16'h0060);
		`chk("power", 1'b1, o_codec_power_up)
		wait_ev(1'b0);
		for (k = 0; k < 4; k++) begin
			r = 16'($urandom);
			i_adc_sample = r;
			w = {2'b01, 13'($urandom), ~w[0]};
			q_dac.push_back(w);
			wr(`CVI_ADDR_TX_DATA, w);
			wait_ev(1'b0);
			rd(`CVI_ADDR_RX_DATA, r);
		end
		$display("done words");
		// Autobuffer both ways, four-word blocks, wrap to base
		nr = n_rx;
		nt = n_tx;
		abuf_on = 1'b1;
		for (k = 0; k < 4; k++) begin
			w = {2'b10, 12'($urandom), k[1:0]};
			u_cvi_mem_model.mem[14'h0100 + k] = w;
			q_dac.push_back(w);
		end
		r = 16'($urandom);
		i_adc_sample = r;
		q_wr.push_back({14'h0200, r});
		wr(`CVI_ADDR_ABUF, 16'h0033);
		for (k = 1; k < 6; k++) begin
			wait_ev(1'b1);
			r = 16'($urandom);
			i_adc_sample = r;
			q_wr.push_back({14'h0200 + 14'(k % 4), r});
		end
		repeat (6) @(negedge i_clk);
		`chk("blk_irq_rx", 1, n_rx - nr)
		`chk("blk_irq_tx", 1, n_tx - nt)
		$display("done autobuffer");
		// Reset in mid-run stops everything and clears the control
		do_reset();
		nr = n_rx + n_tx;
		rd(`CVI_ADDR_CTRL, 16'h0000);
		rd(`CVI_ADDR_ABUF, 16'h0000);
		repeat (3 * S) @(negedge i_clk);
		`chk("irq_reset", nr, n_rx + n_tx)
		$display("done reset");
		close_out();
	end
endmodule
